// >>> shared/epmux_consts.svh
// constants for the eight-bit port with pin multiplexing
// assumes a byte-wide register port and a 200 MHz system clock
`ifndef EPMUX_CONSTS_SVH
`define EPMUX_CONSTS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define EPMUX_ADDR_W 16
`define EPMUX_OFS_DIR 16'hffb5
`define EPMUX_OFS_LATCH 16'hffb7
`define EPMUX_OFS_STAT 16'hffb8
`define EPMUX_RST_DIR 8'h00
`define EPMUX_RST_LATCH 8'h00
`define EPMUX_DIR_READ 8'hff
`define EPMUX_UNMAPPED_READ 8'h00

// ----------------------------------------------------------------
// pin positions
// ----------------------------------------------------------------
`define EPMUX_PIN_T0_CLK 0
`define EPMUX_PIN_T0_WAVE 1
`define EPMUX_PIN_T0_RST 2
`define EPMUX_PIN_T1_CLK 3
`define EPMUX_PIN_T1_WAVE 4
`define EPMUX_PIN_T1_RST 5
`define EPMUX_PIN_PWM0 6
`define EPMUX_PIN_PWM1 7

// ----------------------------------------------------------------
// clear select code that routes a pin to counter reset
// ----------------------------------------------------------------
`define EPMUX_CCLR_EXT 2'h3
`define EPMUX_SYNC_STAGES 2

`endif

// >>> shared/epmux_pkg.sv
// types for the eight-bit port with pin multiplexing
// assumes nothing beyond the constants header
package epmux_pkg;
	// ----------------------------------------------------------------
	// what owns a pin this cycle
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		EPMUX_OWN_GPIO,
		EPMUX_OWN_PERIPH,
		EPMUX_OWN_HOST
	} epmux_owner_t;

	typedef logic [7:0] epmux_byte_t;

	// standby/operating phase of the port
	typedef enum logic [1:0] {
		EPMUX_RUN,
		EPMUX_SW_STBY,
		EPMUX_HW_STBY
	} epmux_phase_t;
endpackage

// >>> src/epmux_sync.sv
// two-stage synchroniser for the eight pin levels
// assumes pins are sampled by mclk; first stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
`include "epmux_consts.svh"

module epmux_sync
	import epmux_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// pins in, synchronised out
	input wire logic [7:0] pin_raw,
	output logic [7:0] pin_sync
);
	// ----------------------------------------------------------------
	// stages
	// ----------------------------------------------------------------
	logic [7:0] meta_ff;
	logic [7:0] sync_ff;

	// first stage is read by the second stage only
	always_ff @(posedge mclk) begin
		if (srst) begin
			meta_ff <= 8'h00;
			sync_ff <= 8'h00;
		end else begin
			meta_ff <= pin_raw;
			sync_ff <= meta_ff;
		end
	end

	assign pin_sync = sync_ff;
endmodule // epmux_sync
`default_nettype wire

// >>> src/epmux_pinsel.sv
// per-pin function selection: owner and driven value of each pin
// assumes peripheral enables are already forced off during standby
`timescale 1ns/10ps
`default_nettype none
`include "epmux_consts.svh"

module epmux_pinsel
	import epmux_pkg::*;
(
	// port state
	input wire logic [7:0] dir,
	input wire logic [7:0] latch,
	// peripheral selects, gated by the caller
	input wire logic slave_mode,
	input wire logic pwm0_oe,
	input wire logic pwm1_oe,
	input wire logic t0_wave_en,
	input wire logic t1_wave_en,
	// peripheral waveforms
	input wire logic pwm0_wave_out,
	input wire logic pwm1_wave_out,
	input wire logic timer0_compare_wave_out,
	input wire logic timer1_compare_wave_out,
	input wire logic host_irq_req_one,
	input wire logic host_irq_req_eleven,
	input wire logic host_irq_req_twelve,
	// result
	output logic [7:0] drive_en,
	output logic [7:0] drive_val
);
	// ----------------------------------------------------------------
	// pin decode
	// ----------------------------------------------------------------
	function automatic epmux_owner_t host_or_gpio(input logic d, input logic sm);
		host_or_gpio = (d && sm) ? EPMUX_OWN_HOST : EPMUX_OWN_GPIO;
	endfunction

	epmux_owner_t own [8];

	// owner of each pin
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			own[i] = EPMUX_OWN_GPIO;
		end
		own[7] = pwm1_oe ? EPMUX_OWN_PERIPH : EPMUX_OWN_GPIO;
		own[6] = pwm0_oe ? EPMUX_OWN_PERIPH : EPMUX_OWN_GPIO;
		own[5] = host_or_gpio(dir[5], slave_mode);
		own[4] = t1_wave_en ? EPMUX_OWN_PERIPH : host_or_gpio(dir[4], slave_mode);
		own[3] = host_or_gpio(dir[3], slave_mode);
		own[1] = t0_wave_en ? EPMUX_OWN_PERIPH : EPMUX_OWN_GPIO;
	end

	// peripheral and host values per pin
	logic [7:0] per_val;
	logic [7:0] host_val;
	assign per_val = {pwm1_wave_out, pwm0_wave_out, 1'b0, timer1_compare_wave_out,
		2'b00, timer0_compare_wave_out, 1'b0};
	assign host_val = {2'b00, host_irq_req_twelve, host_irq_req_one, host_irq_req_eleven, 3'b000};

	// enable and value; a peripheral owner drives regardless of direction
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pin
			always_comb begin
				unique case (own[g])
					EPMUX_OWN_PERIPH: begin
						drive_en[g] = 1'b1;
						drive_val[g] = per_val[g];
					end
					EPMUX_OWN_HOST: begin
						drive_en[g] = 1'b1;
						drive_val[g] = host_val[g];
					end
					EPMUX_OWN_GPIO: begin
						drive_en[g] = dir[g];
						drive_val[g] = latch[g];
					end
					default: begin
						drive_en[g] = 1'b0;
						drive_val[g] = 1'b0;
					end
				endcase
			end
		end
	endgenerate
endmodule // epmux_pinsel
`default_nettype wire

// >>> src/epmux_port.sv
// eight-bit general-purpose port with timer, pwm and host-irq pin sharing
// assumes byte register port, pins synchronous-ish and resynchronised here,
// peripheral control fields delivered as plain inputs from their owners
`timescale 1ns/10ps
`default_nettype none
`include "epmux_consts.svh"

// Notes on behaviour
// - direction bit one drives the pin, zero makes it an input
// - direction register is write-only and reads all ones
// - reset and hardware standby clear the direction register
// - software standby keeps direction, so outputs keep driving
// - software standby returns peripheral pins to plain port control
// - read of an output pin returns the latch bit
// - read of an input pin returns the sampled pin level
// - read-back follows direction even when a peripheral owns the pin
// - latch clears on reset and hardware standby, holds in software standby
// - pin 7 carries pwm 1 wave when its enable is set
// - pin 6 carries pwm 0 wave when its enable is set
// - pin 5 input, general output, or host irq 12 in slave mode
// - pin 5 feeds timer 1 counter reset when both clear selects set
// - pin 4 carries timer 1 compare wave when output select nonzero
// - pin 3 input and timer 1 clock, output or host irq 11
// - pin 2 general, feeds timer 0 counter reset when both selects set
// - pin 1 carries timer 0 compare wave when output select nonzero
// - pin 0 general, serves as timer 0 external clock input
module epmux_port
	import epmux_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// standby controls
	input wire logic hw_standby,
	input wire logic sw_standby,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// pins: output enable low while driving
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe_n,
	// peripheral controls
	input wire logic slave_mode,
	input wire logic pwm0_oe,
	input wire logic pwm1_oe,
	input wire logic [3:0] t0_compare_output_select,
	input wire logic [3:0] t1_compare_output_select,
	input wire logic t0_counter_clear_sel_hi,
	input wire logic t0_counter_clear_sel_lo,
	input wire logic t1_counter_clear_sel_hi,
	input wire logic t1_counter_clear_sel_lo,
	input wire logic t0_ext_clock_sel,
	input wire logic t1_ext_clock_sel,
	// peripheral waveforms
	input wire logic pwm0_wave_out,
	input wire logic pwm1_wave_out,
	input wire logic timer0_compare_wave_out,
	input wire logic timer1_compare_wave_out,
	input wire logic host_irq_req_one,
	input wire logic host_irq_req_eleven,
	input wire logic host_irq_req_twelve,
	// timer inputs taken from pins
	output logic timer0_ext_clock_in,
	output logic timer1_ext_clock_in,
	output logic timer0_counter_reset_in,
	output logic timer1_counter_reset_in
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	epmux_byte_t dir_ff;
	epmux_byte_t latch_ff;
	epmux_phase_t phase_ff;
	epmux_phase_t nxt_phase;
	logic [7:0] pin_sync;
	logic [7:0] drive_en;
	logic [7:0] drive_val;
	logic wr_dir;
	logic wr_latch;
	logic periph_ok;
	epmux_byte_t readback;

	// address decode of a register hit
	function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
		hit = (a == ofs);
	endfunction

	assign wr_dir = reg_wr && hit(reg_addr, `EPMUX_OFS_DIR);
	assign wr_latch = reg_wr && hit(reg_addr, `EPMUX_OFS_LATCH);

	// ----------------------------------------------------------------
	// standby phase
	// ----------------------------------------------------------------
	// hardware standby outranks software standby
	always_comb begin
		if (hw_standby) begin
			nxt_phase = EPMUX_HW_STBY;
		end else if (sw_standby) begin
			nxt_phase = EPMUX_SW_STBY;
		end else begin
			nxt_phase = EPMUX_RUN;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			phase_ff <= EPMUX_RUN;
		end else begin
			phase_ff <= nxt_phase;
		end
	end

	// peripherals are reinitialised in either standby, so they lose their pins
	assign periph_ok = (phase_ff == EPMUX_RUN) && !sw_standby && !hw_standby;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// direction: cleared by reset or hardware standby, held in software standby
	always_ff @(posedge mclk) begin
		if (srst || hw_standby) begin
			dir_ff <= `EPMUX_RST_DIR;
		end else if (wr_dir && !sw_standby) begin
			dir_ff <= reg_wdata;
		end
	end

	// output latch: same reset and standby behaviour
	always_ff @(posedge mclk) begin
		if (srst || hw_standby) begin
			latch_ff <= `EPMUX_RST_LATCH;
		end else if (wr_latch && !sw_standby) begin
			latch_ff <= reg_wdata;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// per-bit select by direction only, whoever owns the pin
	assign readback = (dir_ff & latch_ff) | (~dir_ff & pin_sync);

	// read data stand for exactly the cycle after the strobe
	always_ff @(posedge mclk) begin
		if (srst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (hit(reg_addr, `EPMUX_OFS_DIR)) begin
				reg_rdata <= `EPMUX_DIR_READ;
			end else if (hit(reg_addr, `EPMUX_OFS_LATCH)) begin
				reg_rdata <= readback;
			end else if (hit(reg_addr, `EPMUX_OFS_STAT)) begin
				reg_rdata <= ~pin_oe_n; // live drive state, for debug
			end else begin
				reg_rdata <= `EPMUX_UNMAPPED_READ;
			end
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// synchroniser and pin selection
	// ----------------------------------------------------------------
	epmux_sync u_sync (
		.mclk(mclk),
		.srst(srst),
		.pin_raw(pin_in),
		.pin_sync(pin_sync)
	);

	epmux_pinsel u_sel (
		.dir(dir_ff),
		.latch(latch_ff),
		.slave_mode(slave_mode && periph_ok),
		.pwm0_oe(pwm0_oe && periph_ok),
		.pwm1_oe(pwm1_oe && periph_ok),
		.t0_wave_en((|t0_compare_output_select) && periph_ok),
		.t1_wave_en((|t1_compare_output_select) && periph_ok),
		.pwm0_wave_out(pwm0_wave_out),
		.pwm1_wave_out(pwm1_wave_out),
		.timer0_compare_wave_out(timer0_compare_wave_out),
		.timer1_compare_wave_out(timer1_compare_wave_out),
		.host_irq_req_one(host_irq_req_one),
		.host_irq_req_eleven(host_irq_req_eleven),
		.host_irq_req_twelve(host_irq_req_twelve),
		.drive_en(drive_en),
		.drive_val(drive_val)
	);

	// pin outputs registered; enable is low while driving
	always_ff @(posedge mclk) begin
		if (srst) begin
			pin_out <= 8'h00;
			pin_oe_n <= 8'hff;
		end else begin
			pin_out <= drive_val;
			pin_oe_n <= ~drive_en;
		end
	end

	// ----------------------------------------------------------------
	// timer inputs from pins
	// ----------------------------------------------------------------
	// gated copies so a timer sees no stray edges when the pin is not its own
	always_ff @(posedge mclk) begin
		if (srst) begin
			timer0_ext_clock_in <= 1'b0;
			timer1_ext_clock_in <= 1'b0;
			timer0_counter_reset_in <= 1'b0;
			timer1_counter_reset_in <= 1'b0;
		end else begin
			timer0_ext_clock_in <= t0_ext_clock_sel && pin_sync[`EPMUX_PIN_T0_CLK];
			timer1_ext_clock_in <= t1_ext_clock_sel && pin_sync[`EPMUX_PIN_T1_CLK];
			timer0_counter_reset_in <= ({t0_counter_clear_sel_hi, t0_counter_clear_sel_lo}
				== `EPMUX_CCLR_EXT) && pin_sync[`EPMUX_PIN_T0_RST];
			timer1_counter_reset_in <= ({t1_counter_clear_sel_hi, t1_counter_clear_sel_lo}
				== `EPMUX_CCLR_EXT) && pin_sync[`EPMUX_PIN_T1_RST];
		end
	end
endmodule // epmux_port
`default_nettype wire

// >>> bench/epmux_port_assertions.sv
// checker for the port pins, timer inputs and register reads
// assumes it is bound onto epmux_port and sees only its ports
`timescale 1ns/10ps
`default_nettype none
`include "epmux_consts.svh"
module epmux_port_assertions (
	// clock, reset, standby
	input wire logic mclk,
	input wire logic srst,
	input wire logic hw_standby,
	input wire logic sw_standby,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// pins
	input wire logic [7:0] pin_in,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	// peripherals
	input wire logic pwm0_oe,
	input wire logic pwm1_oe,
	input wire logic pwm0_wave_out,
	input wire logic pwm1_wave_out,
	input wire logic [3:0] t0_compare_output_select,
	input wire logic timer0_compare_wave_out,
	input wire logic t1_counter_clear_sel_hi,
	input wire logic t1_counter_clear_sel_lo,
	input wire logic timer1_counter_reset_in
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);
	// ----
	// sequences
	// ----
	// four edges out of standby, so ownership has settled again
	sequence s_run;
		(!sw_standby && !hw_standby)[*4];
	endsequence
	sequence s_hw;
		hw_standby ##1 hw_standby;
	endsequence
	// ----
	// properties
	// ----
	AST_DIR_READ: assert property (
		reg_rd && reg_addr == `EPMUX_OFS_DIR |=> reg_rdata == `EPMUX_DIR_READ)
		else $error("direction read is not all ones");
	AST_RST_CLEAR: assert property (
		$fell(srst) |-> pin_oe_n == 8'hff && pin_out == 8'h00 && reg_rdata == 8'h00)
		else $error("port not cleared by reset");
	// registers clear on the first standby edge, registered pins follow one edge later
	AST_HW_CLEAR: assert property (
		s_hw |=> pin_oe_n == 8'hff && pin_out == 8'h00)
		else $error("port not cleared in hardware standby");
	AST_PWM1_PIN: assert property (
		s_run ##0 pwm1_oe |=> !pin_oe_n[7] && pin_out[7] == $past(pwm1_wave_out))
		else $error("pin 7 does not carry pwm 1 wave");
	AST_PWM0_PIN: assert property (
		s_run ##0 pwm0_oe |=> !pin_oe_n[6] && pin_out[6] == $past(pwm0_wave_out))
		else $error("pin 6 does not carry pwm 0 wave");
	AST_T0_WAVE: assert property (
		s_run ##0 (t0_compare_output_select != 4'h0)
		|=> !pin_oe_n[1] && pin_out[1] == $past(timer0_compare_wave_out))
		else $error("pin 1 does not carry timer 0 wave");
	AST_SW_HOLD: assert property (
		(sw_standby && !hw_standby)[*3] |-> $stable(pin_out) && $stable(pin_oe_n))
		else $error("pins move during software standby");
	// three clean edges so the synchroniser holds no reset value
	AST_T1_RST: assert property (
		!$past(srst) && !$past(srst, 2) && !$past(srst, 3)
		|-> timer1_counter_reset_in == ($past(t1_counter_clear_sel_hi)
		&& $past(t1_counter_clear_sel_lo) && $past(pin_in[5], 3)))
		else $error("timer 1 counter reset input wrong");
endmodule // epmux_port_assertions
bind epmux_port epmux_port_assertions chk_u (.mclk, .srst, .hw_standby, .sw_standby,
	.reg_addr, .reg_rd, .reg_rdata, .pin_in, .pin_out, .pin_oe_n, .pwm0_oe, .pwm1_oe,
	.pwm0_wave_out, .pwm1_wave_out, .t0_compare_output_select, .timer0_compare_wave_out,
	.t1_counter_clear_sel_hi, .t1_counter_clear_sel_lo, .timer1_counter_reset_in);
`default_nettype wire

// >>> bench/epmux_board.sv
// board model: what hangs on the eight port pins
// assumes the port drives a pin while its enable is low
`timescale 1ns/10ps
`default_nettype none
module epmux_board (
	// port side
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	// outside drivers
	input wire logic [7:0] ext_lvl,
	input wire logic [7:0] ext_en,
	output logic [7:0] pin_in
);
	// port drive first, else outside driver, else pull-up;
	// contention is not modelled, the port simply wins
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_lvl[i] : 1'b1);
		end
	end
endmodule // epmux_board
`default_nettype wire

// >>> bench/epmux_port_tb_top.sv
// self-checking bench for the eight-bit port
// assumes the board model on the pins and the bound checker
`timescale 1ns/10ps
`default_nettype none
`include "epmux_consts.svh"
module epmux_port_tb_top import epmux_pkg::*;;
	logic mclk, srst, hw_standby, sw_standby, reg_wr, reg_rd, slave_mode, pwm0_oe, pwm1_oe;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe_n, ext_lvl, ext_en;
	logic [3:0] t0_compare_output_select, t1_compare_output_select;
	logic t0_counter_clear_sel_hi, t0_counter_clear_sel_lo, t1_counter_clear_sel_hi;
	logic t1_counter_clear_sel_lo, t0_ext_clock_sel, t1_ext_clock_sel;
	logic pwm0_wave_out, pwm1_wave_out, timer0_compare_wave_out, timer1_compare_wave_out;
	logic host_irq_req_one, host_irq_req_eleven, host_irq_req_twelve;
	logic timer0_ext_clock_in, timer1_ext_clock_in;
	logic timer0_counter_reset_in, timer1_counter_reset_in;
	int err_count, compares;
	// ----
	// design and board
	// ----
	epmux_port dut_u (.mclk, .srst, .hw_standby, .sw_standby, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .pin_in, .pin_out, .pin_oe_n, .slave_mode, .pwm0_oe,
		.pwm1_oe, .t0_compare_output_select, .t1_compare_output_select,
		.t0_counter_clear_sel_hi, .t0_counter_clear_sel_lo, .t1_counter_clear_sel_hi,
		.t1_counter_clear_sel_lo, .t0_ext_clock_sel, .t1_ext_clock_sel, .pwm0_wave_out,
		.pwm1_wave_out, .timer0_compare_wave_out, .timer1_compare_wave_out,
		.host_irq_req_one, .host_irq_req_eleven, .host_irq_req_twelve, .timer0_ext_clock_in,
		.timer1_ext_clock_in, .timer0_counter_reset_in, .timer1_counter_reset_in);
	epmux_board board_u (.pin_out, .pin_oe_n, .ext_lvl, .ext_en, .pin_in);
	// ----
	// tasks
	// ----
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [15:0] a, input logic [7:0] exp, input string what);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk(what, reg_rdata, exp);
	endtask
	// waits land just past an edge so registered outputs have settled
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic end_of_test();
		if (err_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// 200 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// ----
	// main sequence
	// ----
	initial begin
		{srst, hw_standby, sw_standby, reg_wr, reg_rd, slave_mode, pwm0_oe, pwm1_oe} = 8'h80;
		{pwm0_wave_out, pwm1_wave_out, timer0_compare_wave_out, timer1_compare_wave_out} = 4'h0;
		{host_irq_req_one, host_irq_req_eleven, host_irq_req_twelve} = 3'h0;
		{t0_counter_clear_sel_hi, t0_counter_clear_sel_lo, t1_counter_clear_sel_hi} = 3'h0;
		{t1_counter_clear_sel_lo, t0_ext_clock_sel, t1_ext_clock_sel} = 3'h0;
		{t0_compare_output_select, t1_compare_output_select} = 8'h00;
		{reg_addr, reg_wdata, ext_lvl, ext_en} = {16'h0000, 8'h00, 8'h5a, 8'hff};
		{err_count, compares} = {32'd0, 32'd0};
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		rdchk(`EPMUX_OFS_DIR, `EPMUX_DIR_READ, "dir read");
		rdchk(`EPMUX_OFS_LATCH, 8'h5a, "input read");
		chk("released", pin_oe_n, 8'hff);
		// mixed directions, two writes with one idle cycle between
		wr(`EPMUX_OFS_DIR, 8'hb0);
		wr(`EPMUX_OFS_LATCH, 8'ha5);
		cyc(3);
		chk("drive", pin_oe_n, 8'h4f);
		chk("drive value", pin_out & 8'hb0, 8'ha0);
		rdchk(`EPMUX_OFS_STAT, 8'hb0, "drive status");
		rdchk(`EPMUX_OFS_LATCH, 8'hea, "mixed read");
		rdchk(`EPMUX_OFS_DIR, `EPMUX_DIR_READ, "dir read");
		// pwm and compare outputs take their pins
		@(posedge mclk);
		{pwm1_oe, pwm0_oe, pwm0_wave_out, timer0_compare_wave_out} <= 4'hf;
		{t1_compare_output_select, t0_compare_output_select} <= 8'h18;
		timer1_compare_wave_out <= 1'b1;
		cyc(4);
		chk("periph drive", pin_oe_n, 8'h0d);
		chk("periph value", pin_out & 8'hf2, 8'h72);
		rdchk(`EPMUX_OFS_LATCH, 8'hea, "owned read");
		// slave mode host requests
		@(posedge mclk);
		{t1_compare_output_select, t0_compare_output_select} <= 8'h00;
		{pwm0_oe, slave_mode, host_irq_req_one, host_irq_req_eleven} <= 4'h7;
		wr(`EPMUX_OFS_DIR, 8'hb8);
		cyc(3);
		chk("host drive", pin_oe_n, 8'h47);
		chk("host value", {5'h00, pin_out[5:3]}, 8'h03);
		// software standby: owners drop, registers hold, writes ignored
		@(posedge mclk);
		sw_standby <= 1'b1;
		cyc(4);
		chk("stby drive", pin_oe_n, 8'h47);
		chk("stby value", pin_out & 8'hb8, 8'ha0);
		wr(`EPMUX_OFS_LATCH, 8'h00);
		@(posedge mclk);
		{sw_standby, slave_mode, pwm1_oe} <= 3'h0;
		rdchk(`EPMUX_OFS_LATCH, 8'he2, "stby kept");
		// timer inputs from pins
		@(posedge mclk);
		ext_lvl <= 8'h2d;
		{t0_counter_clear_sel_hi, t0_counter_clear_sel_lo, t1_counter_clear_sel_hi} <= 3'h7;
		{t1_counter_clear_sel_lo, t0_ext_clock_sel, t1_ext_clock_sel} <= 3'h7;
		wr(`EPMUX_OFS_DIR, 8'h00);
		cyc(5);
		chk("timer in", {4'h0, timer1_counter_reset_in, timer0_counter_reset_in,
			timer1_ext_clock_in, timer0_ext_clock_in}, 8'h0f);
		@(posedge mclk);
		{t1_counter_clear_sel_lo, t0_counter_clear_sel_hi} <= 2'h0;
		cyc(4);
		chk("timer gate", {4'h0, timer1_counter_reset_in, timer0_counter_reset_in,
			timer1_ext_clock_in, timer0_ext_clock_in}, 8'h03);
		// hardware standby clears both registers
		wr(`EPMUX_OFS_DIR, 8'hff);
		wr(`EPMUX_OFS_LATCH, 8'h3c);
		@(posedge mclk);
		hw_standby <= 1'b1;
		cyc(3);
		chk("hw released", pin_oe_n, 8'hff);
		@(posedge mclk);
		hw_standby <= 1'b0;
		rdchk(`EPMUX_OFS_LATCH, 8'h2d, "hw dir");
		wr(`EPMUX_OFS_DIR, 8'hff);
		rdchk(`EPMUX_OFS_LATCH, 8'h00, "hw latch");
		rdchk(16'hffb6, `EPMUX_UNMAPPED_READ, "unmapped");
		// second reset in mid-run
		@(posedge mclk);
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		cyc(1);
		chk("rst released", pin_oe_n, 8'hff);
		end_of_test();
	end
endmodule // epmux_port_tb_top
`default_nettype wire
